/* core/cdrt_core.sv */
/*
  Clock-and-data-recovery tolerance checking and data slicer configuration:
  APB register file, edge tolerance judging, edge-free window supervision,
  pattern-based symbol synchronisation and chip or bit slicing into a FIFO
  that feeds either the framer or the raw chip outputs.
  Assumes the sample stream and pattern matches come from logic on core_clk,
  one sample per sixteenth of a bit, and an APB master on the same clock.
*/
`timescale 1ns/100ps
// Functional notes
// - Chip late tolerance, field 5:3.
// - Chip early tolerance, field 2:0.
// - Bit late tolerance, field 5:3.
// - Bit early tolerance, field 2:0.
// - Lose sync when edge-free samples exceed window.
// - Window counts sixteenths directly, reset 28h.
// - Code 90h: chip mode, code-violation end.
// - Code 94h: chip mode, length-only end.
// - Code 95h: transparent chips to raw outputs.
// - Code 75h: bit mode, no violations.
// - Gap mode 10: A then B.
module cdrt_core
  import cdrt_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              core_clk,         // Core clock, 40 MHz.
  input  wire logic              rst_b,            // Asynchronous reset, active low.
  input  wire logic              clkEn,            // Freezes all state but the reset synchroniser while low.
  input  wire logic              psel,             // APB select.
  input  wire logic              penable,          // APB access phase.
  input  wire logic              pwrite,           // APB write.
  input  wire logic [APB_AW-1:0] paddr,            // APB byte address.
  input  wire logic [31:0]       pwdata,           // APB write data.
  output logic      [31:0]       prdata,           // APB read data.
  output logic                   pready,           // APB ready.
  output logic                   pslverr,          // APB error, unmapped.
  input  wire logic              sampleValid,      // Sample offered.
  input  wire logic              sampleBit,        // Demodulated sample level.
  output logic                   sampleReady,      // Sample taken when high.
  input  wire logic              patternMatchA,    // Pattern A matched, pulse.
  input  wire logic              patternMatchB,    // Pattern B matched, pulse.
  output logic                   rawChipDataOut,   // Raw chip level.
  output logic                   rawChipStrobeOut, // Raw chip strobe, pulse.
  input  wire logic              rawChipReady,     // Raw consumer can take.
  output logic                   framerData,       // Chip or bit to framer.
  output logic                   framerValid,      // Framer word valid.
  input  wire logic              framerReady,      // Framer takes word.
  output logic                   eomCvCriterion,   // Tuned for violation end.
  output logic                   eomLengthOnly,    // Tuned for length end.
  output logic                   transparentMode,  // Framer bypassed.
  output logic                   bitModeOut,       // Bit slicing active.
  output logic                   symbolSynced,     // Synchronisation held.
  output logic                   timingViolation,  // Edge outside windows.
  output logic                   syncLost          // Sync dropped, pulse.
);

  logic             rstSync1_q;
  logic             rstSync2_q;
  logic             rstN;
  logic [TOL_W-1:0] chipTol_q;
  logic [TOL_W-1:0] bitTol_q;
  logic [7:0]       edgeWin_q;
  logic [7:0]       slicer_q;
  cdrt_pat_mode_t   patMode_q;
  logic             patFound_q;
  logic [IDX_W-1:0] regIdx;
  logic             apbAccess;
  logic             apbWrite;
  logic             regHit;
  logic             prevBit_q;
  logic [3:0]       phase_q;
  logic [8:0]       idleCnt_q;
  cdrt_sync_t       sync_q;
  logic             take;
  logic             sampleEdge;
  logic             edgeOk;
  logic             windowExceeded;
  logic             chipPush;
  logic             fifoInReady;
  logic             fifoOutValid;
  logic             fifoOutData;
  logic             fifoOutReady;

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN = rstSync2_q;

  // APB decode; the slave always answers in the first access cycle.
  assign regIdx    = paddr[APB_AW-1:2];
  assign apbAccess = psel & penable;
  assign apbWrite  = apbAccess & pwrite & clkEn;
  assign pready    = 1'b1;
  assign regHit    = (regIdx == IDX_CHIP_TOL) || (regIdx == IDX_BIT_TOL)
                  || (regIdx == IDX_EDGE_WIN) || (regIdx == IDX_SLICER)
                  || (regIdx == IDX_PATTERN)  || (regIdx == IDX_STATUS);
  assign pslverr   = apbAccess & ~regHit;

  // Configuration registers; bits above each field are dropped on write.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      chipTol_q <= RST_CHIP_TOL;
      bitTol_q  <= RST_BIT_TOL;
      edgeWin_q <= RST_EDGE_WIN;
      slicer_q  <= RST_SLICER;
      patMode_q <= PAT_SEQ;
    end else if (apbWrite) begin
      case (regIdx)
        IDX_CHIP_TOL: chipTol_q <= pwdata[TOL_W-1:0];
        IDX_BIT_TOL:  bitTol_q  <= pwdata[TOL_W-1:0];
        IDX_EDGE_WIN: edgeWin_q <= pwdata[7:0];
        IDX_SLICER:   slicer_q  <= pwdata[7:0];
        IDX_PATTERN:  patMode_q <= cdrt_pat_mode_t'(pwdata[PAT_MSB:0]);
        default:      ;
      endcase
    end
  end

  // Read mux; unused and unmapped bits read as zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (apbAccess && !pwrite) begin
      case (regIdx)
        IDX_CHIP_TOL: prdata[TOL_W-1:0] = chipTol_q;
        IDX_BIT_TOL:  prdata[TOL_W-1:0] = bitTol_q;
        IDX_EDGE_WIN: prdata[7:0] = edgeWin_q;
        IDX_SLICER:   prdata[7:0] = slicer_q;
        IDX_PATTERN:  prdata[PAT_MSB:0] = patMode_q;
        IDX_STATUS: begin
          prdata[STAT_SYNC]  = (sync_q == SY_LOCKED);
          prdata[STAT_FOUND] = patFound_q;
          prdata[STAT_IDLE_MSB:STAT_IDLE_LSB] = idleCnt_q;
        end
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // Sample acceptance and edge detection; the FIFO back-pressures the stream.
  assign sampleReady = fifoInReady;
  assign take        = clkEn & sampleValid & fifoInReady;
  assign sampleEdge  = take & (sampleBit != prevBit_q);

  cdrt_edge_judge u_judge (
    .phase            (phase_q),
    .chipLate         (chipTol_q[LATE_MSB:LATE_LSB]),
    .chipEarly        (chipTol_q[EARLY_MSB:EARLY_LSB]),
    .bitLate          (bitTol_q[LATE_MSB:LATE_LSB]),
    .bitEarly         (bitTol_q[EARLY_MSB:EARLY_LSB]),
    .accept           (edgeOk),
    .snapPhase_unused (),
    .nextPhase        ()
  );

  // Phase counts taken samples, so accepted edges never shift the ideal border grid.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      prevBit_q <= 1'b0;
      phase_q   <= PH_BIT_BORDER;
    end else if (take) begin
      prevBit_q <= sampleBit;
      phase_q   <= phase_q + 1'b1;
    end
  end

  // Edge-free sample counter, restarted by every edge and saturating.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      idleCnt_q <= '0;
    end else if (sampleEdge) begin
      idleCnt_q <= '0;
    end else if (take && idleCnt_q != IDLE_MAX) begin
      idleCnt_q <= idleCnt_q + 1'b1;
    end
  end

  // The window value is a count of sixteenths, compared without scaling.
  assign windowExceeded = (idleCnt_q > {1'b0, edgeWin_q});

  // Synchronisation: patterns establish it, a long edge-free run ends it.
  // In gap mode the wait between A and B relies on a widened window.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sync_q <= SY_SEARCH;
    end else if (clkEn) begin
      case (sync_q)
        SY_SEARCH: begin
          if ((patMode_q == PAT_PARALLEL || patMode_q == PAT_EXTENDED)
              && (patternMatchA || patternMatchB)) begin
            sync_q <= SY_LOCKED;
          end else if (patternMatchA) begin
            sync_q <= SY_SECOND;
          end
        end
        SY_SECOND: begin
          if (patternMatchB) begin
            sync_q <= SY_LOCKED;
          end else if (windowExceeded) begin
            sync_q <= SY_SEARCH;
          end
        end
        SY_LOCKED: begin
          if (windowExceeded) begin
            sync_q <= SY_SEARCH;
          end
        end
        default: sync_q <= SY_SEARCH;
      endcase
    end
  end
  assign symbolSynced = (sync_q == SY_LOCKED);

  // Event pulses and the sticky pattern flag; set wins over clear.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      timingViolation <= 1'b0;
      syncLost        <= 1'b0;
      patFound_q      <= 1'b0;
    end else if (clkEn) begin
      timingViolation <= sampleEdge & ~edgeOk;
      syncLost        <= (sync_q == SY_LOCKED) & windowExceeded;
      if (sync_q == SY_SECOND && patternMatchB) begin
        patFound_q <= 1'b1;
      end else if (apbWrite && regIdx == IDX_STATUS) begin
        patFound_q <= 1'b0;
      end
    end
  end

  // Slicer mode decode from the configuration code.
  assign eomCvCriterion  = (slicer_q == SLC_CHIP_CV);
  assign eomLengthOnly   = (slicer_q == SLC_CHIP_LEN);
  assign transparentMode = (slicer_q == SLC_CHIP_TRN);
  assign bitModeOut      = (slicer_q == SLC_BIT);

  // Chips are sliced at both chip centres, bits at the second one only.
  assign chipPush = take & symbolSynced
                  & ((phase_q == PH_CHIP_B_MID)
                  | (!bitModeOut && phase_q == PH_CHIP_A_MID));

  cdrt_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstN     (rstN),
    .clkEn    (clkEn),
    .inValid  (chipPush),
    .inReady  (fifoInReady),
    .inData   (sampleBit),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // The FIFO drains to the raw outputs or to the framer, never both.
  assign fifoOutReady = transparentMode ? rawChipReady : framerReady;
  assign framerValid  = fifoOutValid & ~transparentMode;
  assign framerData   = fifoOutData;

  // Raw chip outputs: level held, strobe one cycle per chip.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rawChipDataOut   <= 1'b0;
      rawChipStrobeOut <= 1'b0;
    end else if (clkEn) begin
      rawChipStrobeOut <= transparentMode & fifoOutValid & rawChipReady;
      if (transparentMode && fifoOutValid && rawChipReady) begin
        rawChipDataOut <= fifoOutData;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN);

  a_chip_late_ok: assert property (
    sampleEdge && phase_q >= PH_CHIP_BORDER
    && (phase_q - PH_CHIP_BORDER) <= {1'b0, chipTol_q[LATE_MSB:LATE_LSB]}
    |=> !timingViolation)
    else $error("Late chip edge inside window flagged");

  a_chip_early_ok: assert property (
    sampleEdge && phase_q < PH_CHIP_BORDER && phase_q != PH_BIT_BORDER
    && (PH_CHIP_BORDER - phase_q) <= {1'b0, chipTol_q[EARLY_MSB:EARLY_LSB]}
    |=> !timingViolation && idleCnt_q == '0)
    else $error("Early chip edge inside window flagged");

  a_bit_late_ok: assert property (
    sampleEdge && phase_q <= {1'b0, bitTol_q[LATE_MSB:LATE_LSB]}
    |=> !timingViolation)
    else $error("Late bit edge inside window flagged");

  a_bit_early_ok: assert property (
    sampleEdge && phase_q > PH_CHIP_BORDER
    && (PH_PER_BIT - {1'b0, phase_q}) <= {2'b00, bitTol_q[EARLY_MSB:EARLY_LSB]}
    |=> !timingViolation)
    else $error("Early bit edge inside window flagged");

  a_sync_loss: assert property (
    clkEn && sync_q == SY_LOCKED && idleCnt_q > {1'b0, edgeWin_q}
    |=> sync_q == SY_SEARCH && syncLost)
    else $error("Sync kept past edge-free window");

  a_sync_hold: assert property (
    clkEn && sync_q == SY_LOCKED && idleCnt_q <= {1'b0, edgeWin_q}
    |=> sync_q == SY_LOCKED)
    else $error("Sync dropped inside edge-free window");

  a_mode_route: assert property (
    transparentMode |-> !framerValid && !eomCvCriterion && !bitModeOut)
    else $error("Transparent mode still feeds framer");

  a_gap_pair: assert property (
    clkEn && sync_q == SY_SECOND && patternMatchB |=> symbolSynced ##0 patFound_q)
    else $error("Pattern B after A did not lock");

  a_edge_restart: assert property (
    sampleEdge && !edgeOk |=> timingViolation && idleCnt_q == '0)
    else $error("Violating edge not flagged or count kept");

  a_tol_read: assert property (
    apbAccess && !pwrite && regIdx == IDX_CHIP_TOL |-> prdata[31:TOL_W] == '0)
    else $error("Unused tolerance bits read nonzero");

endmodule // cdrt_core

/* core/cdrt_edge_judge.sv */
/*
  Judges one detected edge against the chip and bit border tolerances and
  gives the phase just after the chosen border, which the core's sample counter ignores.
  Assumes phase 0 is the ideal bit border and phase 8 the mid-bit chip border.
*/
`timescale 1ns/100ps
module cdrt_edge_judge
  import cdrt_pkg::*;
(
  input  wire logic [3:0] phase,     // Phase of the sample holding the edge.
  input  wire logic [2:0] chipLate,  // Samples allowed after a chip border.
  input  wire logic [2:0] chipEarly, // Samples allowed before a chip border.
  input  wire logic [2:0] bitLate,   // Samples allowed after a bit border.
  input  wire logic [2:0] bitEarly,  // Samples allowed before a bit border.
  output logic            accept,    // Edge lies inside a window.
  output logic            snapPhase_unused, // Kept low; reserved.
  output logic [3:0]      nextPhase  // Phase just after the chosen border; left unconnected in the core.
);

  logic [3:0] afterChip;
  logic [3:0] beforeChip;
  logic [4:0] beforeBit;
  logic       bitOk;
  logic       chipOk;
  logic       firstHalf;

  // Distances from the nearest borders on each side.
  assign firstHalf        = (phase < PH_CHIP_BORDER);
  assign afterChip        = phase - PH_CHIP_BORDER;
  assign beforeChip       = PH_CHIP_BORDER - phase;
  assign beforeBit        = PH_PER_BIT - {1'b0, phase};
  assign snapPhase_unused = 1'b0;

  // Window tests; the closer border wins when both windows hold the edge.
  always_comb begin
    if (firstHalf) begin
      bitOk  = (phase <= {1'b0, bitLate});
      chipOk = (beforeChip <= {1'b0, chipEarly});
      nextPhase = (bitOk && (phase <= PH_CHIP_A_MID || !chipOk))
                  ? PH_AFTER_BIT : PH_AFTER_CHIP;
    end else begin
      chipOk = (afterChip <= {1'b0, chipLate});
      bitOk  = (phase != PH_BIT_BORDER)
               && (beforeBit <= {2'b00, bitEarly});
      nextPhase = (chipOk && (phase <= PH_CHIP_B_MID || !bitOk))
                  ? PH_AFTER_CHIP : PH_AFTER_BIT;
    end
    accept = bitOk | chipOk;
  end

endmodule // cdrt_edge_judge

/* core/cdrt_fifo.sv */
/*
  Small synchronous FIFO for the recovered chip stream, with valid and ready
  on both sides and honest full and empty.
  Assumes one clock, an active-low reset already synchronised, and a clock
  enable that freezes all state while low.
*/
`timescale 1ns/100ps
module cdrt_fifo
  import cdrt_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,      // Core clock.
  input  wire logic             rstN,     // Synchronised reset, active low.
  input  wire logic             clkEn,    // Freezes all state while low.
  input  wire logic             inValid,  // Writer offers a word.
  output logic                  inReady,  // Room for a word.
  input  wire logic [WIDTH-1:0] inData,   // Word to store.
  output logic                  outValid, // A word is waiting.
  input  wire logic             outReady, // Reader takes the word.
  output logic      [WIDTH-1:0] outData   // Oldest word.
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Handshake terms; the frozen clock enable blocks both sides.
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = clkEn & inValid & inReady;
  assign pop      = clkEn & outValid & outReady;
  assign outData  = mem[rdPtr_q];

  // Storage array, written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at the depth; count tracks occupancy.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Occupancy never passes the depth.
  a_fifo_bound: assert property (@(posedge clk) disable iff (!rstN)
    count_q <= (AW+1)'(DEPTH))
    else $error("FIFO occupancy above depth");

endmodule // cdrt_fifo

/* core/cdrt_pkg.sv */
/*
  Shared constants for the clock-and-data-recovery tolerance and slicer
  configuration block: register indices, field layout, reset values, slicer
  codes, sample phase positions and the synchroniser state encoding.
  Assumes sixteen demodulated samples per bit and two chips per bit.
*/
package cdrt_pkg;

  // APB address width and the word-index slice of the address.
  localparam int          APB_AW        = 12;
  localparam int          IDX_W         = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0]  IDX_CHIP_TOL  = 10'h049;
  localparam logic [9:0]  IDX_BIT_TOL   = 10'h04A;
  localparam logic [9:0]  IDX_EDGE_WIN  = 10'h04B;
  localparam logic [9:0]  IDX_SLICER    = 10'h04C;
  localparam logic [9:0]  IDX_PATTERN   = 10'h051;
  localparam logic [9:0]  IDX_STATUS    = 10'h052;

  // Reset values.
  localparam logic [5:0]  RST_CHIP_TOL  = 6'h0C;
  localparam logic [5:0]  RST_BIT_TOL   = 6'h1E;
  localparam logic [7:0]  RST_EDGE_WIN  = 8'h28;
  localparam logic [7:0]  RST_SLICER    = 8'h90;

  // Tolerance field layout: late in bits 5:3, early in bits 2:0; pattern mode in bits 1:0.
  localparam int          TOL_W         = 6;
  localparam int          LATE_MSB      = 5;
  localparam int          LATE_LSB      = 3;
  localparam int          EARLY_MSB     = 2;
  localparam int          EARLY_LSB     = 0;
  localparam int          PAT_MSB       = 1;

  // Status register layout.
  localparam int          STAT_SYNC     = 0;
  localparam int          STAT_FOUND    = 1;
  localparam int          STAT_IDLE_LSB = 8;
  localparam int          STAT_IDLE_MSB = 16;

  // Slicer configuration codes.
  localparam logic [7:0]  SLC_CHIP_CV   = 8'h90;
  localparam logic [7:0]  SLC_CHIP_LEN  = 8'h94;
  localparam logic [7:0]  SLC_CHIP_TRN  = 8'h95;
  localparam logic [7:0]  SLC_BIT       = 8'h75;

  // Sample phases within one bit and the edge-free counter limit.
  localparam logic [3:0]  PH_BIT_BORDER  = 4'h0;
  localparam logic [3:0]  PH_CHIP_BORDER = 4'h8;
  localparam logic [3:0]  PH_CHIP_A_MID  = 4'h4;
  localparam logic [3:0]  PH_CHIP_B_MID  = 4'hC;
  localparam logic [3:0]  PH_AFTER_BIT   = 4'h1;
  localparam logic [3:0]  PH_AFTER_CHIP  = 4'h9;
  localparam logic [4:0]  PH_PER_BIT     = 5'h10;
  localparam logic [8:0]  IDLE_MAX       = 9'h1FF;

  // Pattern detection modes.
  typedef enum logic [1:0] {
    PAT_SEQ      = 2'b00,
    PAT_PARALLEL = 2'b01,
    PAT_GAP      = 2'b10,
    PAT_EXTENDED = 2'b11
  } cdrt_pat_mode_t;

  // Symbol synchroniser states.
  typedef enum logic [1:0] {
    SY_SEARCH = 2'b00,
    SY_SECOND = 2'b01,
    SY_LOCKED = 2'b10
  } cdrt_sync_t;

endpackage

/* test/cdrt_far_side.sv */
/*
  Far-side model of the recovery block: a demodulated sample source that
  repeats one sixteen-sample pattern per bit, and a framer and raw chip sink.
  Assumes the core's valid and ready handshakes on one clock, and that the
  core's bit phase starts at zero with the first sample taken after reset.
*/
`timescale 1ns/100ps
module cdrt_far_side (
  input  wire logic        clk,          // Core clock.
  input  wire logic        run,          // Offer samples while high.
  input  wire logic [15:0] pattern,      // Sample level for each bit phase.
  input  wire logic        stall,        // Downstream holds off while high.
  input  wire logic        sampleReady,  // Core takes the offered sample.
  output logic             sampleValid,  // Sample offered.
  output logic             sampleBit,    // Sample level.
  output logic             framerReady,  // Framer pops a word.
  output logic             rawChipReady  // Raw consumer can take a chip.
);
  logic [3:0] phaseQ = 4'h0;  // Phase of the next sample, kept in step with the core.

  // The phase moves only on a taken sample, so a refused sample is offered again.
  always_ff @(posedge clk) begin
    if (sampleValid && sampleReady)
      phaseQ <= phaseQ + 4'h1;
    sampleValid  <= run;
    framerReady  <= !stall && (framerReady !== 1'b1);
    rawChipReady <= !stall;
  end

  // Outside a valid sample the line shows the opposite level, not a stale one.
  assign sampleBit = sampleValid ? pattern[phaseQ] : !pattern[phaseQ];
endmodule // cdrt_far_side

/* test/test_cdrt_core.sv */
/*
  Self-checking bench for cdrt_core: registers over APB, edge tolerance
  windows, edge-free window supervision, slicer modes and the chip buffer.
  Assumes cdrt_far_side feeds samples and drains the framer and raw outputs.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_cdrt_core
  import cdrt_pkg::*;
;
  localparam logic [11:0] chipAddr = 12'h124, bitAddr = 12'h128, winAddr = 12'h12C;
  localparam logic [11:0] slcAddr = 12'h130, patAddr = 12'h144;
  logic        core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, sampleValid, sampleBit, sampleReady, framerReady;
  logic        rawChipReady, rawChipDataOut, rawChipStrobeOut, framerData, framerValid;
  logic        eomCvCriterion, eomLengthOnly, transparentMode, bitModeOut;
  logic        symbolSynced, timingViolation, syncLost;
  logic        patternMatchA = 1'b0, patternMatchB = 1'b0, run = 1'b0, stall = 1'b0;
  logic [15:0] pattern = 16'h0000;
  logic [7:0]  codes [5] = '{8'h94, 8'h95, 8'h75, 8'h33, 8'h90};
  logic [3:0]  flags [5] = '{4'h4, 4'h2, 4'h1, 4'h0, 4'h8};
  logic [5:0]  tolChip [10] = '{6'h00, 6'h00, 6'h05, 6'h04, 6'h00,
                                6'h00, 6'h08, 6'h00, 6'h00, 6'h00};
  logic [5:0]  tolBit [10] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h10,
                               6'h08, 6'h00, 6'h00, 6'h02, 6'h01};
  logic [15:0] pats [10] = '{16'h00FF, 16'h00F8, 16'h00F8, 16'h00F8, 16'h00FC,
                             16'h00FC, 16'h01FF, 16'h01FF, 16'hC0FF, 16'hC0FF};
  logic [9:0]  badCase = 10'h2AA;
  wire  [3:0]  modeFlags = {eomCvCriterion, eomLengthOnly, transparentMode, bitModeOut};
  int          errors = 0, comparisons = 0, cycles = 0, viols = 0, losses = 0;
  int          strobes = 0, highs = 0, base;

  cdrt_core i_cdrt_core (.core_clk, .rst_b, .clkEn(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleValid, .sampleBit, .sampleReady,
    .patternMatchA, .patternMatchB, .rawChipDataOut, .rawChipStrobeOut, .rawChipReady,
    .framerData, .framerValid, .framerReady, .eomCvCriterion, .eomLengthOnly,
    .transparentMode, .bitModeOut, .symbolSynced, .timingViolation, .syncLost);

  cdrt_far_side i_cdrt_far_side (.clk(core_clk), .run, .pattern, .stall, .sampleReady,
    .sampleValid, .sampleBit, .framerReady, .rawChipReady);

  // The clock toggles every half period of 12.5 ns.
  always #12.5 core_clk = ~core_clk;

  // Event pulses are counted here, and a hung run is cut short.
  always @(posedge core_clk) begin
    cycles++;
    viols += int'(timingViolation === 1'b1);
    losses += int'(syncLost === 1'b1);
    strobes += int'(rawChipStrobeOut === 1'b1);
    highs += int'(rawChipStrobeOut === 1'b1 && rawChipDataOut === 1'b1);
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer; on a read, d and e are the expected data and error.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w) `CHK({pslverr, prdata}, {e, d})
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Streams a pattern for n cycles, then lets late pulses land.
  task automatic stream(input logic [15:0] p, input int n);
    pattern <= p;
    run <= 1'b1;
    repeat (n) @(posedge core_clk);
    run <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // Pattern A alone must not lock; A then B must.
  task automatic lock();
    patternMatchA <= 1'b1;
    @(posedge core_clk);
    patternMatchA <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(symbolSynced, 1'b0)
    patternMatchB <= 1'b1;
    @(posedge core_clk);
    patternMatchB <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(symbolSynced, 1'b1)
  endtask

  // Main sequence: registers, slicer codes, tolerances, sync, buffer, raw output.
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    apb(1'b0, chipAddr, 32'h0000000C, 1'b0);
    apb(1'b0, bitAddr, 32'h0000001E, 1'b0);
    apb(1'b0, winAddr, 32'h00000028, 1'b0);
    apb(1'b0, slcAddr, 32'h00000090, 1'b0);
    apb(1'b0, 12'hFFC, 32'h00000000, 1'b1);
    apb(1'b1, chipAddr, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, chipAddr, 32'h0000003F, 1'b0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, slcAddr, {24'h000000, codes[i]}, 1'b0);
      `CHK(modeFlags, flags[i])
    end
    $display("test registers and slicer codes done");
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, chipAddr, {26'h0000000, tolChip[i]}, 1'b0);
      apb(1'b1, bitAddr, {26'h0000000, tolBit[i]}, 1'b0);
      base = viols;
      stream(pats[i], 64);
      `CHK(viols - base, badCase[i] ? 4 : 0)
    end
    $display("test edge tolerances done");
    apb(1'b1, winAddr, 32'h00000010, 1'b0);
    lock();
    apb(1'b0, 12'h148, 32'h00000103, 1'b0);
    stream(16'h00FF, 64);
    base = losses;
    stream(16'h0000, 8);
    `CHK(symbolSynced, 1'b1)
    stream(16'h0000, 12);
    `CHK({symbolSynced, losses - base}, {1'b0, 32'h00000001})
    apb(1'b1, winAddr, 32'h000000FF, 1'b0);
    apb(1'b1, patAddr, 32'h00000002, 1'b0);
    lock();
    stall <= 1'b1;
    stream(16'h00FF, 64);
    `CHK({sampleReady, framerValid, framerData}, 3'h3)
    stall <= 1'b0;
    repeat (12) @(posedge core_clk);
    `CHK({sampleReady, framerValid}, 2'h2)
    apb(1'b1, slcAddr, 32'h00000095, 1'b0);
    base = strobes;
    stream(16'h00FF, 32);
    `CHK({framerValid, strobes - base, highs}, {1'b0, 32'h00000004, 32'h00000002})
    $display("test sync, buffer and raw output done");
    wrap_up();
  end
endmodule // test_cdrt_core
